// *** common/gate_pkg.sv ***
// Package with register map, field positions and timing constants of the gate.
package gate_pkg;
  // Timebase: reference tick and the system clock period, in ns.
  localparam int TICK_NS = 20;
  localparam int CLK_NS = 100;
  localparam int TICKS_PER_CLK = CLK_NS / TICK_NS;
  // Setting limits in ns, converted to reference ticks.
  localparam int DELAY_MAX_NS = 100_000_000;
  localparam int WIDTH_MIN_NS = 100;
  localparam int WIDTH_MAX_NS = 100_000_000;
  localparam int FINE_LIMIT_NS = 320;
  localparam int COARSE_LIMIT_NS = 1000;
  localparam int LONG_MIN_NS = 1000;
  localparam int TW = 23;
  localparam logic [TW-1:0] DELAY_MAX_T = TW'(DELAY_MAX_NS / TICK_NS);
  localparam logic [TW-1:0] WIDTH_MIN_T = TW'(WIDTH_MIN_NS / TICK_NS);
  localparam logic [TW-1:0] WIDTH_MAX_T = TW'(WIDTH_MAX_NS / TICK_NS);
  localparam logic [TW-1:0] FINE_T = TW'(FINE_LIMIT_NS / TICK_NS);
  localparam logic [TW-1:0] COARSE_T = TW'(COARSE_LIMIT_NS / TICK_NS);
  localparam logic [TW-1:0] LONG_MIN_T = TW'(LONG_MIN_NS / TICK_NS);
  localparam logic [TW-1:0] STEP_T = TW'(TICKS_PER_CLK);
  // Register byte addresses.
  localparam int AW = 8;
  localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AW-1:0] ADDR_DELAY = 8'h04;
  localparam logic [AW-1:0] ADDR_WIDTH = 8'h08;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h0c;
  localparam logic [AW-1:0] ADDR_PERIOD = 8'h10;
  // Control register fields.
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_SRC_LO = 1;
  localparam int CTRL_SLOPE = 3;
  localparam int CTRL_WIDTH_CLOSE = 4;
  localparam int CTRL_NARROW = 5;
  localparam int CTRL_GE_1GHZ = 6;
  // Status register fields.
  localparam int STAT_GATE = 0;
  localparam int STAT_DELAYING = 1;
  localparam int STAT_COUNT_LO = 16;
  localparam int CW = 16;
  // Trigger source codes.
  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_LINE = 2'h2;
  // Reset values.
  localparam logic [6:0] CTRL_RESET = 7'h10;
  localparam logic [TW-1:0] DELAY_RESET = 23'h000000;
  localparam logic [TW-1:0] WIDTH_RESET = 23'h000032;
  // Gate sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DELAY = 3'b010,
    ST_GATE = 3'b100
  } gate_st_e;
endpackage : gate_pkg

// *** hdl/gate_ctrl.sv ***
// Triggered measurement gate with delay, width and close mode, APB registers.
module gate_ctrl
  import gate_pkg::*;
#(
  parameter int INT_PERIOD_DEF = 10000,
  parameter int PW = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_trig,
  input wire logic line_trig,
  input wire logic burst_on,
  output logic gate_open,
  output logic delay_active
);

  // Parameters the logic cannot serve are refused at elaboration.
  // The period counter must fit PW bits and the clock must span a tick.
  if (PW < 2 || PW > 31 || INT_PERIOD_DEF < 1 ||
      INT_PERIOD_DEF >= (1 << PW) || TICKS_PER_CLK < 1) begin : g_bad
    $error("gate_ctrl: unsupported parameter values");
  end

  localparam logic [PW-1:0] PERIOD_RESET = PW'(INT_PERIOD_DEF);

  // Register map, one aligned 32-bit word for each register:
  //   Control: enable, trigger source, slope, close mode, burst flags.
  //   Delay: trigger delay in 20 ns ticks, stored after quantising.
  //   Width: gate width in 20 ns ticks, stored after quantising.
  //   Status: gate and delay levels, count of completed gates.
  //   Period: internal trigger period in clock cycles.
  // An unmapped address answers with an error and reads as zero, and a
  // write to it changes nothing. The status word is read-only.
  // Reset leaves the gate disabled on the internal source, rising slope,
  // width close, no delay and a width of one microsecond.
  //
  // Bus timing: the answer comes one cycle after the setup edge, so every transfer
  // with clk_en high completes without a wait state. Read data is captured at the
  // setup edge and stands until the next setup.
  //
  // Gate timing: the counters step once per clock, which is five ticks of
  // the 20 ns reference, so delay and width round up to whole clocks.
  // A delay of zero opens the gate at the same edge that sees the trigger.
  // Triggers that arrive while a delay or gate runs are dropped silently.
  // The close mode and the burst level are read live on every cycle, so a
  // change of mode during a gate takes effect at once.
  // Edge detection compares the pin with its level one cycle earlier, so
  // a trigger pulse must last at least one clock to be seen.
  // The count of completed gates wraps silently when it overflows.

  typedef struct packed {
    // Sequencer, its tick counter and the internal trigger counter.
    gate_st_e st;
    logic [TW-1:0] remain;
    logic [PW-1:0] int_cnt;
    // Trigger history for edge detection.
    logic prev_ext;
    logic prev_line;
    // Control register fields.
    logic enable;
    logic [1:0] src;
    logic slope_fall;
    logic width_close;
    logic narrow;
    logic ge_1ghz;
    // Timing settings in ticks, and the internal trigger period.
    logic [TW-1:0] delay;
    logic [TW-1:0] width;
    logic [PW-1:0] period;
    // Status kept for software and for the output pins.
    logic [CW-1:0] gate_count;
    logic gate;
    logic delaying;
    // Bus answer, registered so every output comes from a flip-flop.
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } state_s;

  state_s cur;
  state_s nxt;

  // Keeps the highest set bit and the bit just below it.
  // This is the two-significant-bit rounding used above one microsecond.
  // Values below two set positions come back unchanged.
  // Rounding is always downward, so only the width minimum and the zero-period rule can make a stored setting grow.
  function automatic logic [TW-1:0] keep_two(input logic [TW-1:0] v);
    logic [TW-1:0] r;
    r = '0;
    for (int i = TW - 1; i >= 1; i--) begin
      if (v[i] && r == '0) begin
        r[i] = 1'b1;
        r[i-1] = v[i-1];
      end
    end
    if (r == '0) begin
      r = v;
    end
    return r;
  endfunction : keep_two

  // Clamps and quantises a delay setting in ticks.
  // Below 320 ns every tick is kept, up to one microsecond the step is two
  // ticks, and above that two significant bits remain.
  function automatic logic [TW-1:0] quant_delay(input logic [TW-1:0] v);
    logic [TW-1:0] c;
    c = (v > DELAY_MAX_T) ? DELAY_MAX_T : v;
    if (c < FINE_T) begin
      quant_delay = c;
    end else if (c < COARSE_T) begin
      quant_delay = {c[TW-1:1], 1'b0};
    end else begin
      quant_delay = keep_two(c);
    end
  endfunction : quant_delay

  // Clamps and quantises a gate width setting in ticks.
  // The width is first held between its limits, then rounded, so the
  // smallest stored width is 100 ns.
  function automatic logic [TW-1:0] quant_width(input logic [TW-1:0] v);
    logic [TW-1:0] c;
    c = (v < WIDTH_MIN_T) ? WIDTH_MIN_T : v;
    c = (c > WIDTH_MAX_T) ? WIDTH_MAX_T : c;
    if (c < COARSE_T) begin
      quant_width = c;
    end else begin
      quant_width = keep_two(c);
    end
  endfunction : quant_width

  // Reports whether a tick count runs out within one clock period.
  // A counter is never decremented past zero: the last step may be short,
  // which rounds the interval up to whole clocks.
  function automatic logic expires(input logic [TW-1:0] t);
    return t <= STEP_T;
  endfunction : expires

  // Decoded trigger, burst and bus conditions of the present cycle.
  logic trig_hit;
  logic ext_edge;
  logic line_edge;
  logic int_tick;
  logic short_ok;
  logic [TW-1:0] eff_width;
  logic setup;
  logic wr_take;

  // Edge detection on the selected trigger inputs and the internal tick.
  always_comb begin
    ext_edge = cur.slope_fall ? (cur.prev_ext && !ext_trig)
                              : (!cur.prev_ext && ext_trig);
    line_edge = cur.slope_fall ? (cur.prev_line && !line_trig)
                               : (!cur.prev_line && line_trig);
    // The internal trigger fires as the period counter wraps to zero.
    int_tick = (cur.int_cnt == '0);
    // Only the selected source may start a gate; code 3 is never stored.
    unique case (cur.src)
      SRC_INT: trig_hit = int_tick;
      SRC_EXT: trig_hit = ext_edge;
      SRC_LINE: trig_hit = line_edge;
      default: trig_hit = 1'b0;
    endcase
    // Narrow burst needs the carrier flag as well, else the wide minimum
    // width of one microsecond applies.
    short_ok = cur.narrow && cur.ge_1ghz;
    eff_width = (!short_ok && cur.width < LONG_MIN_T) ? LONG_MIN_T
                                                       : cur.width;
    // Bus phases as the slave sees them.
    setup = psel && !penable;
    wr_take = psel && penable && cur.ready && pwrite;
  end

  // Next-state logic for sequencer, trigger history and register file.
  always_comb begin
    nxt = cur;
    // Trigger history is sampled on every enabled cycle.
    nxt.prev_ext = ext_trig;
    nxt.prev_line = line_trig;
    // The internal period counter runs free whether or not enabled.
    nxt.int_cnt = (cur.int_cnt == '0) ? cur.period - PW'(1)
                                      : cur.int_cnt - PW'(1);
    unique case (cur.st)
      // Idle: accept a qualifying trigger when the gate is enabled.
      ST_IDLE: begin
        if (cur.enable && trig_hit) begin
          if (cur.delay == '0) begin
            nxt.st = ST_GATE;
            nxt.remain = eff_width;
          end else begin
            nxt.st = ST_DELAY;
            nxt.remain = cur.delay;
          end
        end
      end
      // Delay: count down, then load the width and open the gate.
      ST_DELAY: begin
        if (expires(cur.remain)) begin
          nxt.st = ST_GATE;
          nxt.remain = eff_width;
        end else begin
          nxt.remain = cur.remain - STEP_T;
        end
      end
      // Gate: close on width or on burst end, as the close mode says.
      ST_GATE: begin
        if (cur.width_close) begin
          if (expires(cur.remain)) begin
            nxt.st = ST_IDLE;
            nxt.gate_count = cur.gate_count + CW'(1);
          end else begin
            nxt.remain = cur.remain - STEP_T;
          end
        end else if (!burst_on) begin
          nxt.st = ST_IDLE;
          nxt.gate_count = cur.gate_count + CW'(1);
        end
      end
      // An illegal state code falls back to idle.
      default: nxt.st = ST_IDLE;
    endcase
    // Status levels follow the next state, so outputs stay registered.
    nxt.gate = (nxt.st == ST_GATE);
    nxt.delaying = (nxt.st == ST_DELAY);

    // APB: ready comes one cycle after setup, so no transfer has a wait state while clk_en stays high.
    // Read data is chosen at the setup edge and held until the next one.
    nxt.ready = setup;
    nxt.slverr = 1'b0;
    if (setup) begin
      // Unused bits of a word read as zero.
      nxt.rdata = '0;
      unique case (paddr)
        ADDR_CTRL: begin
          nxt.rdata[CTRL_ENABLE] = cur.enable;
          nxt.rdata[CTRL_SRC_LO +: 2] = cur.src;
          nxt.rdata[CTRL_SLOPE] = cur.slope_fall;
          nxt.rdata[CTRL_WIDTH_CLOSE] = cur.width_close;
          nxt.rdata[CTRL_NARROW] = cur.narrow;
          nxt.rdata[CTRL_GE_1GHZ] = cur.ge_1ghz;
        end
        ADDR_DELAY: nxt.rdata[TW-1:0] = cur.delay;
        ADDR_WIDTH: nxt.rdata[TW-1:0] = cur.width;
        ADDR_STATUS: begin
          nxt.rdata[STAT_GATE] = cur.gate;
          nxt.rdata[STAT_DELAYING] = cur.delaying;
          nxt.rdata[STAT_COUNT_LO +: CW] = cur.gate_count;
        end
        ADDR_PERIOD: nxt.rdata[PW-1:0] = cur.period;
        default: nxt.slverr = 1'b1;
      endcase
    end

    // Register writes take effect at the completing access edge.
    if (wr_take) begin
      unique case (paddr)
        ADDR_CTRL: begin
          nxt.enable = pwdata[CTRL_ENABLE];
          // The unused source code selects the internal trigger.
          if (pwdata[CTRL_SRC_LO +: 2] == 2'h3) begin
            nxt.src = SRC_INT;
          end else begin
            nxt.src = pwdata[CTRL_SRC_LO +: 2];
          end
          nxt.slope_fall = pwdata[CTRL_SLOPE];
          nxt.width_close = pwdata[CTRL_WIDTH_CLOSE];
          nxt.narrow = pwdata[CTRL_NARROW];
          nxt.ge_1ghz = pwdata[CTRL_GE_1GHZ];
        end
        ADDR_DELAY: nxt.delay = quant_delay(pwdata[TW-1:0]);
        ADDR_WIDTH: nxt.width = quant_width(pwdata[TW-1:0]);
        ADDR_PERIOD: begin
          // A zero period would stall the internal trigger; it becomes one.
          nxt.period = (pwdata[PW-1:0] == '0) ? PW'(1) : pwdata[PW-1:0];
        end
        default: nxt.enable = cur.enable;
      endcase
    end
  end

  // State register; the clock enable freezes everything while low.
  // The bus answer freezes too, so a master must wait out a low enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '{
        st: ST_IDLE,
        remain: '0,
        int_cnt: '0,
        prev_ext: 1'b0,
        prev_line: 1'b0,
        enable: CTRL_RESET[CTRL_ENABLE],
        src: CTRL_RESET[CTRL_SRC_LO +: 2],
        slope_fall: CTRL_RESET[CTRL_SLOPE],
        width_close: CTRL_RESET[CTRL_WIDTH_CLOSE],
        narrow: CTRL_RESET[CTRL_NARROW],
        ge_1ghz: CTRL_RESET[CTRL_GE_1GHZ],
        delay: DELAY_RESET,
        width: WIDTH_RESET,
        period: PERIOD_RESET,
        gate_count: '0,
        gate: 1'b0,
        delaying: 1'b0,
        rdata: '0,
        ready: 1'b0,
        slverr: 1'b0
      };
    end else if (clk_en) begin
      cur <= nxt;
    end
  end

  // Outputs straight from the state register.
  // No output passes through logic, so none can glitch.
  assign prdata = cur.rdata;
  assign pready = cur.ready;
  assign pslverr = cur.slverr;
  assign gate_open = cur.gate;
  assign delay_active = cur.delaying;

endmodule : gate_ctrl

// *** dv/gate_chk.sv ***
// Checker of port relations of the measurement gate block.
module gate_chk
  import gate_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_trig,
  input wire logic line_trig,
  input wire logic burst_on,
  input wire logic gate_open,
  input wire logic delay_active
);
  // All checks run on the one clock and stop during reset.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_after_setup_a:
    assert property (psel && !penable && clk_en |=> pready)
    else $error("ready missing after setup");
  ready_pulse_a:
    assert property (pready && clk_en |=> !pready)
    else $error("ready longer than one cycle");
  err_with_ready_a:
    assert property (pslverr |-> pready)
    else $error("error without ready");
  err_read_zero_a:
    assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  gate_delay_excl_a:
    assert property (!(gate_open && delay_active))
    else $error("gate and delay both high");
  delay_then_gate_a:
    assert property ($fell(delay_active) |-> gate_open)
    else $error("gate did not follow delay");
  idle_gap_a:
    assert property ($fell(gate_open) |-> !delay_active &&
      !$past(delay_active))
    else $error("restart without idle cycle");
  no_delay_in_gate_a:
    assert property ($rose(delay_active) |-> !$past(gate_open))
    else $error("delay started during gate");
  enable_freeze_a:
    assert property (!clk_en |=> $stable(gate_open) && $stable(delay_active))
    else $error("state moved while clock disabled");
  cover property ($fell(delay_active));
  cover property ($fell(gate_open) && burst_on);
  cover property (pslverr);
  cover property (!clk_en && gate_open);
endmodule : gate_chk

// *** dv/trig_src.sv ***
// Model of the trigger sources and the burst detector.
module trig_src (
  input wire logic pclk,
  input wire logic ext_run,
  input wire logic ext_lvl,
  input wire logic line_lvl,
  input wire logic burst_req,
  output logic ext_trig,
  output logic line_trig,
  output logic burst_on
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tog = 1'b0;
  // A running source toggles every clock, else it follows the bench level.
  always @(posedge pclk) begin
    tog <= ~tog;
  end
  assign ext_trig = ext_run ? tog : ext_lvl;
  assign line_trig = line_lvl;
  assign burst_on = burst_req;
endmodule : trig_src

// *** dv/triggered_measurement_gate_tb.sv ***
// Testbench of the measurement gate block.
module triggered_measurement_gate_tb;
  import gate_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic ext_trig, line_trig, burst_on, gate_open, delay_active;
  logic ext_run, ext_lvl, line_lvl, burst_req, e;
  int fails, samples_checked, cyc, i, n;
  localparam logic [31:0] RT [4][2] = '{'{32'h0, 32'h10}, '{32'h4, 32'h0},
    '{32'h8, 32'h32}, '{32'h10, 32'h14}};
  localparam logic [31:0] QT [7][3] = '{'{32'h4, 32'h0, 32'h0},
    '{32'h4, 32'hf, 32'hf}, '{32'h4, 32'h11, 32'h10},
    '{32'h4, 32'h32, 32'h30}, '{32'h8, 32'h3, 32'h5},
    '{32'h8, 32'h31, 32'h31}, '{32'h8, 32'h64, 32'h60}};
  localparam logic [31:0] MT [3][2] = '{'{32'h13, 32'ha},
    '{32'h33, 32'ha}, '{32'h73, 32'h4}};
  gate_ctrl #(.INT_PERIOD_DEF(20), .PW(24)) dut (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_trig(ext_trig),
    .line_trig(line_trig), .burst_on(burst_on), .gate_open(gate_open),
    .delay_active(delay_active));
  trig_src src (.pclk(pclk), .ext_run(ext_run), .ext_lvl(ext_lvl),
    .line_lvl(line_lvl), .burst_req(burst_req), .ext_trig(ext_trig),
    .line_trig(line_trig), .burst_on(burst_on));
  // Clock of 100 ns period.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Cuts a hang short.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      report_and_stop();
    end
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    samples_checked++;
    if (y !== x) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, x, y);
    end
  endtask : chk
  // One APB transfer; answer is taken at the edge that sees pready.
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a[AW-1:0];
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task cfg(input logic [31:0] c, input logic [31:0] d);
    apb(1'b1, 32'h0, c);
    apb(1'b1, 32'h4, d);
    apb(1'b1, 32'h8, 32'h14);
    repeat (30) @(posedge pclk);
  endtask : cfg
  // Counts delay and gate cycles up to the end of the first gate.
  task run(input int ed, input int eg);
    int d, g;
    d = 0;
    g = 0;
    while (gate_open === 1'b1) @(posedge pclk); // Skip a gate already open.
    for (n = 0; n < 80; n++) begin
      @(posedge pclk);
      if (delay_active === 1'b1) d++;
      if (gate_open === 1'b1) g++;
      else if (g > 0) break;
    end
    chk("delay cycles", ed, d);
    chk("gate cycles", eg, g);
  endtask : run
  initial begin
    {presetn, clk_en, psel, penable, pwrite, paddr, pwdata} = '0;
    {ext_run, ext_lvl, line_lvl, burst_req, fails, samples_checked} = '0;
    cyc = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    clk_en <= 1'b1;
    burst_req <= 1'b1;
    for (i = 0; i < 4; i++) begin
      apb(1'b0, RT[i][0], 32'h0);
      chk("reset value", RT[i][1], q);
    end
    apb(1'b0, 32'h14, 32'h0);
    chk("unmapped read", 32'h0, q);
    chk("unmapped error", 32'h1, {31'h0, e});
    $display("test registers done");
    for (i = 0; i < 7; i++) begin
      apb(1'b1, QT[i][0], QT[i][1]);
      apb(1'b0, QT[i][0], 32'h0);
      chk("stored setting", QT[i][2], q);
    end
    $display("test quantise done");
    cfg(32'h13, 32'h11);
    ext_run <= 1'b1;
    run(4, 10);
    ext_run <= 1'b0;
    cfg(32'h13, 32'h0);
    ext_run <= 1'b1;
    run(0, 10);
    ext_run <= 1'b0;
    $display("test retrigger done");
    for (i = 0; i < 3; i++) begin
      cfg(MT[i][0], 32'h0);
      ext_lvl <= 1'b1;
      run(0, MT[i][1]);
      ext_lvl <= 1'b0;
    end
    $display("test burst width done");
    cfg(32'h1b, 32'h0);
    ext_lvl <= 1'b1;
    run(0, 0);
    ext_lvl <= 1'b0;
    run(0, 10);
    cfg(32'h15, 32'h0);
    line_lvl <= 1'b1;
    run(0, 10);
    cfg(32'h11, 32'h0);
    run(0, 10);
    $display("test sources done");
    cfg(32'h3, 32'h0);
    ext_lvl <= 1'b1;
    for (i = 0; i < 50 && gate_open !== 1'b1; i++) @(posedge pclk);
    repeat (12) @(posedge pclk);
    clk_en <= 1'b0;
    repeat (3) @(posedge pclk);
    clk_en <= 1'b1;
    chk("gate held", 32'h1, {31'h0, gate_open});
    burst_req <= 1'b0;
    for (n = 0; n < 9 && gate_open === 1'b1; n++) @(posedge pclk);
    chk("burst close", 32'h1, {31'h0, n <= 3});
    apb(1'b0, 32'hc, 32'h0);
    chk("status idle", 32'h0, q & 32'h3);
    $display("test burst close done");
    report_and_stop();
  end
endmodule : triggered_measurement_gate_tb
bind gate_ctrl gate_chk chk_i (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ext_trig(ext_trig), .line_trig(line_trig),
  .burst_on(burst_on), .gate_open(gate_open),
  .delay_active(delay_active));
